// >>> inc/bf_pkg.sv
// Constants, register map and types for breaker failure supervision
package bf_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned MS_PER_S = 1000;
	localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;
	localparam int unsigned FORCE_TIMEOUT_MIN = 5;
	localparam int unsigned FORCE_TIMEOUT_MS = FORCE_TIMEOUT_MIN * 60 * MS_PER_S;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int OPT_W = 20;
	localparam int REC_N = 8;
	localparam int PTR_W = 3;
	localparam int CNT_W = 4;
	localparam int PCT_W = 7;

	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_OPTIME = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_START_CNT = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_TRIP_CNT = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_PASSWORD = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h1C;
	localparam logic [ADDR_W-1:0] OFF_REC_INFO = 8'h20;
	// Records: 0x80 + 16*slot, word 0 date, 1 time of day, 2 delay percent
	localparam int REC_SEL_BIT = 7;
	localparam logic [1:0] REC_DATE_W = 2'h0;
	localparam logic [1:0] REC_TIME_W = 2'h1;
	localparam logic [1:0] REC_PCT_W = 2'h2;

	localparam int CTRL_SEL_LSB = 0;
	localparam int CTRL_FORCE_BIT = 4;
	localparam int CTRL_AUTH_BIT = 8;
	localparam int STATUS_BLOCKED_BIT = 0;
	localparam int STATUS_START_BIT = 1;
	localparam int STATUS_TRIP_BIT = 2;
	localparam int IRQ_START_BIT = 0;
	localparam int IRQ_TRIP_BIT = 1;
	localparam int IRQ_FORCE_END_BIT = 2;
	localparam int IRQ_W = 3;
	localparam int INFO_PTR_LSB = 0;
	localparam int INFO_CNT_LSB = 8;

	localparam logic [1:0] SEL_ONE = 2'h1;
	localparam logic [1:0] SEL_TWO = 2'h2;
	localparam logic [1:0] SEL_RST = 2'h1;
	localparam logic [OPT_W-1:0] OPTIME_RST = 20'h000C8;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
	localparam logic [PCT_W-1:0] PCT_FULL = 7'h64;
	// Arbitrary unlock key
	localparam logic [DATA_W-1:0] PASSWORD_KEY = 32'h5A5A0001;

	typedef enum logic [1:0] {ST_IDLE, ST_TIMING, ST_BACKUP} state_t;
endpackage

// >>> inc/timebase_if.sv
// Millisecond tick and force timeout signals between top and timebase
`timescale 1ns/100ps
interface timebase_if;
	logic msTick;
	logic forceArm;
	logic forceExpire;
	modport src(output msTick, output forceExpire, input forceArm);
	modport snk(input msTick, input forceExpire, output forceArm);
endinterface

// >>> rtl/ms_timebase.sv
// Millisecond enable divider and test force timeout counter
`timescale 1ns/100ps
module ms_timebase #(
	parameter int unsigned MS_CYCLES = bf_pkg::MS_CYCLES,
	parameter int unsigned FORCE_MS = bf_pkg::FORCE_TIMEOUT_MS
) (
	input wire logic clk,
	input wire logic rst,
	timebase_if.src tb
);
	import bf_pkg::*;
	localparam int DW = $clog2(MS_CYCLES);
	localparam int FW = $clog2(FORCE_MS + 1);

	logic [DW-1:0] divQ;
	logic [FW-1:0] forceMsQ;
	logic tickQ;
	logic expireQ;
	wire lastDiv = divQ == DW'(MS_CYCLES - 1);
	wire lastMs = forceMsQ == FW'(FORCE_MS - 1);

	always_ff @(posedge clk) begin
		if (rst || lastDiv) begin
			divQ <= '0;
		end else begin
			divQ <= divQ + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			tickQ <= 1'b0;
		end else begin
			tickQ <= lastDiv;
		end
	end

	// Counts whole ms while force is on, restarts after each expiry
	always_ff @(posedge clk) begin
		if (rst || !tb.forceArm || expireQ) begin
			forceMsQ <= '0;
		end else if (tickQ) begin
			forceMsQ <= forceMsQ + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			expireQ <= 1'b0;
		end else begin
			expireQ <= tb.forceArm && tickQ && lastMs && !expireQ;
		end
	end

	assign tb.msTick = tickQ;
	assign tb.forceExpire = expireQ;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	expire_needs_arm_a: assert property (
		tb.forceExpire |-> $past(tb.forceArm) && $past(forceMsQ) == FW'(FORCE_MS - 1))
		else $error("force expiry without a full armed timeout");
	tick_spacing_a: assert property (tb.msTick |=> !tb.msTick[*2])
		else $error("ms tick repeated too soon");
endmodule

// >>> rtl/breaker_failure_backup_trip.sv
// Breaker failure supervision stage with backup trip and fault records
`timescale 1ns/100ps
module breaker_failure_backup_trip #(
	parameter int unsigned MS_CYCLES = bf_pkg::MS_CYCLES,
	parameter int unsigned FORCE_MS = bf_pkg::FORCE_TIMEOUT_MS
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [bf_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [bf_pkg::DATA_W-1:0] writedata,
	output logic [bf_pkg::DATA_W-1:0] readdata,
	output logic waitrequest,
	input wire logic relayOneCtrl,
	input wire logic relayTwoCtrl,
	input wire logic stageBlock,
	input wire logic [bf_pkg::DATA_W-1:0] dateStamp,
	input wire logic [bf_pkg::DATA_W-1:0] timeOfDayMs,
	output logic startOut,
	output logic backupTrip,
	output logic irq
);
	import bf_pkg::*;

	timebase_if tb();
	ms_timebase #(
		.MS_CYCLES(MS_CYCLES),
		.FORCE_MS(FORCE_MS)
	) uTimebase (
		.clk(clk),
		.rst(rst),
		.tb(tb)
	);

	// Pin synchronisers: relay one, relay two, block
	logic [2:0] metaQ;
	logic [2:0] syncQ;
	always_ff @(posedge clk) begin
		if (rst) begin
			metaQ <= 3'h0;
			syncQ <= 3'h0;
		end else begin
			metaQ <= {stageBlock, relayTwoCtrl, relayOneCtrl};
			syncQ <= metaQ;
		end
	end
	wire relayOne = syncQ[0];
	wire relayTwo = syncQ[1];
	wire blocked = syncQ[2];

	// Bus slave: one wait state, answer on the second edge
	logic ackQ;
	logic [DATA_W-1:0] readdataQ;
	logic [DATA_W-1:0] rdMux;
	always_ff @(posedge clk) begin
		if (rst) begin
			ackQ <= 1'b0;
		end else begin
			ackQ <= (read || write) && !ackQ;
		end
	end
	assign waitrequest = !ackQ;
	assign readdata = readdataQ;

	wire doWrite = write && ackQ;
	wire doRead = read && ackQ;
	wire wrCtrl = doWrite && address == OFF_CTRL;
	wire wrOpt = doWrite && address == OFF_OPTIME;
	wire wrStatus = doWrite && address == OFF_STATUS;
	wire wrStartCnt = doWrite && address == OFF_START_CNT;
	wire wrTripCnt = doWrite && address == OFF_TRIP_CNT;
	wire wrPwd = doWrite && address == OFF_PASSWORD;
	wire wrMask = doWrite && address == OFF_IRQ_MASK;
	wire rdIrq = doRead && address == OFF_IRQ_STAT;
	wire recHit = address[REC_SEL_BIT];
	wire [PTR_W-1:0] recSlot = address[6:4];
	wire [1:0] recWord = address[3:2];

	// Settings, writable only while unlocked
	logic authQ;
	logic [1:0] relaySelQ;
	logic [OPT_W-1:0] opTimeQ;
	always_ff @(posedge clk) begin
		if (rst) begin
			authQ <= 1'b0;
			relaySelQ <= SEL_RST;
			opTimeQ <= OPTIME_RST;
		end else begin
			if (wrPwd) begin
				authQ <= writedata == PASSWORD_KEY;
			end
			if (wrCtrl && authQ) begin
				relaySelQ <= writedata[CTRL_SEL_LSB +: 2];
			end
			if (wrOpt && authQ) begin
				opTimeQ <= writedata[OPT_W-1:0];
			end
		end
	end

	// Force flag; a setting write wins over the timeout in the same cycle
	logic forceQ;
	logic fStartQ;
	logic fTripQ;
	always_ff @(posedge clk) begin
		if (rst) begin
			forceQ <= 1'b0;
		end else if (wrCtrl && authQ) begin
			forceQ <= writedata[CTRL_FORCE_BIT];
		end else if (tb.forceExpire) begin
			forceQ <= 1'b0;
		end
	end
	assign tb.forceArm = forceQ;

	always_ff @(posedge clk) begin
		if (rst || !forceQ) begin
			fStartQ <= 1'b0;
			fTripQ <= 1'b0;
		end else if (wrStatus) begin
			fStartQ <= writedata[STATUS_START_BIT];
			fTripQ <= writedata[STATUS_TRIP_BIT];
		end
	end

	// Supervised relay control and failure timing
	wire supervised = relaySelQ == SEL_ONE ? relayOne :
		relaySelQ == SEL_TWO ? relayTwo : 1'b0;
	state_t stateQ;
	state_t stateD;
	logic [OPT_W-1:0] elapsedQ;
	wire reached = elapsedQ >= opTimeQ;

	always_comb begin
		stateD = stateQ;
		case (stateQ)
			ST_IDLE: begin
				if (supervised) begin
					stateD = ST_TIMING;
				end
			end
			ST_TIMING: begin
				if (!supervised) begin
					stateD = ST_IDLE;
				end else if (reached) begin
					stateD = ST_BACKUP;
				end
			end
			ST_BACKUP: begin
				if (!supervised) begin
					stateD = ST_IDLE;
				end
			end
			default: begin
				stateD = ST_IDLE;
			end
		endcase
		if (blocked) begin
			stateD = ST_IDLE;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			stateQ <= ST_IDLE;
		end else begin
			stateQ <= stateD;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || stateQ != ST_TIMING || stateD != ST_TIMING) begin
			elapsedQ <= '0;
		end else if (tb.msTick) begin
			elapsedQ <= elapsedQ + 1'b1;
		end
	end

	wire startEv = stateQ == ST_IDLE && stateD == ST_TIMING;
	wire tripEv = stateQ == ST_TIMING && stateD == ST_BACKUP;
	wire endEv = stateQ == ST_TIMING && stateD != ST_TIMING;

	assign startOut = !blocked && (forceQ ? fStartQ : stateQ != ST_IDLE);
	assign backupTrip = !blocked && (forceQ ? fTripQ : stateQ == ST_BACKUP);

	// Counters, an event in the clearing cycle still counts
	logic [DATA_W-1:0] startCntQ;
	logic [DATA_W-1:0] tripCntQ;
	always_ff @(posedge clk) begin
		if (rst) begin
			startCntQ <= '0;
			tripCntQ <= '0;
		end else begin
			startCntQ <= (wrStartCnt ? '0 : startCntQ) + DATA_W'(startEv);
			tripCntQ <= (wrTripCnt ? '0 : tripCntQ) + DATA_W'(tripEv);
		end
	end

	// Fault records, ring of eight
	function automatic logic [PCT_W-1:0] pctOf(
		input logic [OPT_W-1:0] el,
		input logic [OPT_W-1:0] set
	);
		logic [OPT_W+PCT_W-1:0] num;
		num = (OPT_W+PCT_W)'(el) * (OPT_W+PCT_W)'(PCT_FULL);
		if (set == '0 || el >= set) begin
			return PCT_FULL;
		end
		return PCT_W'(num / (OPT_W+PCT_W)'(set));
	endfunction

	logic [DATA_W-1:0] startDateQ;
	logic [DATA_W-1:0] startTimeQ;
	logic [DATA_W-1:0] recDate [REC_N];
	logic [DATA_W-1:0] recTime [REC_N];
	logic [PCT_W-1:0] recPct [REC_N];
	logic [PTR_W-1:0] wrPtrQ;
	logic [CNT_W-1:0] recCntQ;

	always_ff @(posedge clk) begin
		if (startEv) begin
			startDateQ <= dateStamp;
			startTimeQ <= timeOfDayMs;
		end
		if (endEv) begin
			recDate[wrPtrQ] <= startDateQ;
			recTime[wrPtrQ] <= startTimeQ;
			recPct[wrPtrQ] <= pctOf(elapsedQ, opTimeQ);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wrPtrQ <= '0;
			recCntQ <= '0;
		end else if (endEv) begin
			wrPtrQ <= wrPtrQ + 1'b1;
			if (recCntQ != CNT_W'(REC_N)) begin
				recCntQ <= recCntQ + 1'b1;
			end
		end
	end

	// Interrupts: a read clears only bits it returned; set still wins
	logic [IRQ_W-1:0] irqStatQ;
	logic [IRQ_W-1:0] irqMaskQ;
	wire [IRQ_W-1:0] irqEv = {tb.forceExpire, tripEv, startEv};
	always_ff @(posedge clk) begin
		if (rst) begin
			irqStatQ <= '0;
			irqMaskQ <= IRQ_MASK_RST;
		end else begin
			irqStatQ <= (rdIrq ? irqStatQ & ~readdataQ[IRQ_W-1:0] : irqStatQ)
				| irqEv;
			if (wrMask) begin
				irqMaskQ <= writedata[IRQ_W-1:0];
			end
		end
	end
	assign irq = |(irqStatQ & irqMaskQ);

	// Read data
	always_comb begin
		rdMux = '0;
		case (address)
			OFF_CTRL: begin
				rdMux[CTRL_SEL_LSB +: 2] = relaySelQ;
				rdMux[CTRL_FORCE_BIT] = forceQ;
				rdMux[CTRL_AUTH_BIT] = authQ;
			end
			OFF_OPTIME: rdMux[OPT_W-1:0] = opTimeQ;
			OFF_STATUS: begin
				rdMux[STATUS_BLOCKED_BIT] = blocked;
				rdMux[STATUS_START_BIT] = startOut;
				rdMux[STATUS_TRIP_BIT] = backupTrip;
			end
			OFF_START_CNT: rdMux = startCntQ;
			OFF_TRIP_CNT: rdMux = tripCntQ;
			OFF_IRQ_STAT: rdMux[IRQ_W-1:0] = irqStatQ;
			OFF_IRQ_MASK: rdMux[IRQ_W-1:0] = irqMaskQ;
			OFF_REC_INFO: begin
				rdMux[INFO_PTR_LSB +: PTR_W] = wrPtrQ;
				rdMux[INFO_CNT_LSB +: CNT_W] = recCntQ;
			end
			default: rdMux = '0;
		endcase
		if (recHit) begin
			case (recWord)
				REC_DATE_W: rdMux = recDate[recSlot];
				REC_TIME_W: rdMux = recTime[recSlot];
				REC_PCT_W: rdMux = DATA_W'(recPct[recSlot]);
				default: rdMux = '0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			readdataQ <= '0;
		end else if (read && !ackQ) begin
			readdataQ <= rdMux;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	timer_start_a: assert property (
		stateQ == ST_IDLE && supervised && !blocked |=> stateQ == ST_TIMING && elapsedQ == '0)
		else $error("supervised relay did not start timing");
	backup_on_time_a: assert property (
		stateQ == ST_TIMING && supervised && !blocked && reached
		|=> stateQ == ST_BACKUP)
		else $error("backup trip missed after operate time");
	backup_hold_a: assert property (
		stateQ == ST_BACKUP && supervised && !blocked && !forceQ
		|=> backupTrip || blocked || forceQ)
		else $error("backup trip dropped while relay still active");
	relay_select_a: assert property (
		relaySelQ == SEL_ONE && relayTwo && !relayOne |-> !supervised)
		else $error("relay one selection followed relay two");
	force_write_a: assert property (
		wrStatus && !forceQ |=> !fStartQ && !fTripQ)
		else $error("status forced without force flag");
	force_expire_a: assert property (tb.forceExpire && !wrCtrl |=> !forceQ)
		else $error("force flag not cleared by timeout");
	start_count_a: assert property (
		startEv && !wrStartCnt |=> startCntQ == $past(startCntQ) + 1)
		else $error("start counter did not advance");
	locked_optime_a: assert property (
		wrOpt && !authQ |=> opTimeQ == $past(opTimeQ))
		else $error("operate time changed while locked");
	ring_advance_a: assert property (
		endEv |=> wrPtrQ == $past(wrPtrQ) + 1'b1)
		else $error("record pointer did not advance");
	trip_pct_a: assert property (
		tripEv |=> recPct[$past(wrPtrQ)] == PCT_FULL)
		else $error("trip record not at full percent");
	blocked_quiet_a: assert property (
		blocked |-> !startOut && !backupTrip ##1 elapsedQ == '0)
		else $error("blocked stage produced output");
	early_release_a: assert property (
		stateQ == ST_TIMING && !supervised |=> stateQ == ST_IDLE && !backupTrip)
		else $error("early release did not reset timer");

	backup_seen_c: cover property (tripEv);
	early_release_c: cover property (stateQ == ST_TIMING && stateD == ST_IDLE);
	ring_wrap_c: cover property (endEv && recCntQ == CNT_W'(REC_N));
	force_expire_c: cover property (tb.forceExpire);
endmodule

// >>> sim/trip_relay_model.sv
// Behavioural pair of primary trip relays driven by output matrix commands
`timescale 1ns/100ps
module trip_relay_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic cmdOne,
	input wire logic cmdTwo,
	output logic relayOneCtrl,
	output logic relayTwoCtrl
);
	// Coil drive follows the matrix command one cycle later
	always_ff @(posedge clk) begin
		relayOneCtrl <= rst ? 1'b0 : cmdOne;
		relayTwoCtrl <= rst ? 1'b0 : cmdTwo;
	end
endmodule

// >>> sim/breaker_failure_backup_trip_test.sv
// Self-checking bench for breaker failure supervision
`timescale 1ns/100ps
`define CHECK(got, exp) begin \
	numChecks++; \
	if ((got) !== (exp)) begin \
		nErrors++; \
		$display("[FAIL] %0t got %h exp %h", $time, got, exp); \
	end \
end
module breaker_failure_backup_trip_test;
	import bf_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic read = 1'b0;
	logic write = 1'b0;
	logic stageBlock = 1'b0;
	logic cmdOne = 1'b0;
	logic cmdTwo = 1'b0;
	logic [7:0] address = 8'h00;
	logic [31:0] writedata = 32'h0;
	logic [31:0] dateStamp = 32'h00012345;
	logic [31:0] timeOfDayMs = 32'h0001E240;
	logic [31:0] readdata, q;
	logic waitrequest, startOut, backupTrip, irq, relayOneCtrl, relayTwoCtrl;
	logic [2:0] slot;
	int nErrors = 0;
	int numChecks = 0;
	int cycles = 0;

	always #5 clk = ~clk;

	breaker_failure_backup_trip #(.MS_CYCLES(4), .FORCE_MS(5)) uut (
		.clk(clk), .rst(rst), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .relayOneCtrl(relayOneCtrl),
		.relayTwoCtrl(relayTwoCtrl), .stageBlock(stageBlock),
		.dateStamp(dateStamp), .timeOfDayMs(timeOfDayMs),
		.startOut(startOut), .backupTrip(backupTrip), .irq(irq));

	trip_relay_model relays (.clk(clk), .rst(rst), .cmdOne(cmdOne),
		.cmdTwo(cmdTwo), .relayOneCtrl(relayOneCtrl),
		.relayTwoCtrl(relayTwoCtrl));

	task automatic busOp(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		address <= a;
		write <= w;
		read <= !w;
		writedata <= d;
		@(posedge clk);
		while (waitrequest !== 1'b0) @(posedge clk);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		busOp(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		busOp(1'b0, a, 32'h0);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	function automatic logic [7:0] rec(input logic [2:0] s,
		input logic [1:0] w);
		return {1'b1, s, w, 2'b00};
	endfunction

	task automatic tSettings;
		rd(OFF_CTRL);
		`CHECK(q, 32'h00000001)
		rd(OFF_START_CNT);
		`CHECK(q, 32'h0)
		rd(8'h40);
		`CHECK(q, 32'h0)
		wr(OFF_OPTIME, 32'h5);
		rd(OFF_OPTIME);
		`CHECK(q, 32'h000000C8)
		wr(OFF_PASSWORD, PASSWORD_KEY);
		wr(OFF_OPTIME, 32'h5);
		rd(OFF_OPTIME);
		`CHECK(q, 32'h00000005)
		wr(OFF_IRQ_MASK, 32'h7);
	endtask

	task automatic tTrip;
		rd(OFF_REC_INFO);
		slot = q[2:0];
		rd(OFF_IRQ_STAT);
		cmdOne <= 1'b1;
		cyc(5);
		`CHECK(startOut, 1'b1)
		timeOfDayMs <= 32'h0001E2A4;
		dateStamp <= 32'h00012346;
		cyc(5);
		`CHECK(backupTrip, 1'b0)
		repeat (40) if (backupTrip !== 1'b1) @(posedge clk);
		`CHECK(backupTrip, 1'b1)
		cyc(20);
		`CHECK(backupTrip, 1'b1)
		`CHECK(irq, 1'b1)
		rd(OFF_IRQ_STAT);
		`CHECK(q, 32'h3)
		cyc(1);
		`CHECK(irq, 1'b0)
		cmdOne <= 1'b0;
		cyc(5);
		`CHECK(backupTrip, 1'b0)
		rd(OFF_TRIP_CNT);
		`CHECK(q, 32'h1)
		rd(rec(slot, REC_PCT_W));
		`CHECK(q, 32'h64)
		rd(rec(slot, REC_TIME_W));
		`CHECK(q, 32'h0001E240)
		rd(rec(slot, REC_DATE_W));
		`CHECK(q, 32'h00012345)
		wr(OFF_START_CNT, 32'h0);
		rd(OFF_START_CNT);
		`CHECK(q, 32'h0)
	endtask

	task automatic tEarly;
		rd(OFF_REC_INFO);
		slot = q[2:0];
		repeat (9) begin
			cmdOne <= 1'b1;
			cyc(12);
			`CHECK(backupTrip, 1'b0)
			cmdOne <= 1'b0;
			cyc(6);
		end
		rd(OFF_REC_INFO);
		`CHECK(q, {20'h0, 4'h8, 5'h0, 3'(slot + 3'h1)})
		rd(rec(slot, REC_PCT_W));
		`CHECK(q < 32'd100, 1'b1)
		rd(OFF_TRIP_CNT);
		`CHECK(q, 32'h1)
		rd(OFF_START_CNT);
		`CHECK(q, 32'h9)
		wr(OFF_TRIP_CNT, 32'h0);
		rd(OFF_TRIP_CNT);
		`CHECK(q, 32'h0)
	endtask

	task automatic tSelectBlock;
		wr(OFF_CTRL, 32'h2);
		cmdOne <= 1'b1;
		cyc(8);
		`CHECK(startOut, 1'b0)
		cmdTwo <= 1'b1;
		cyc(5);
		`CHECK(startOut, 1'b1)
		repeat (40) if (backupTrip !== 1'b1) @(posedge clk);
		`CHECK(backupTrip, 1'b1)
		cmdOne <= 1'b0;
		cyc(5);
		`CHECK(backupTrip, 1'b1)
		stageBlock <= 1'b1;
		cyc(4);
		`CHECK({startOut, backupTrip}, 2'b00)
		rd(OFF_STATUS);
		`CHECK(q, 32'h1)
		cyc(30);
		`CHECK(backupTrip, 1'b0)
		stageBlock <= 1'b0;
		cyc(10);
		`CHECK(backupTrip, 1'b0)
		cmdTwo <= 1'b0;
		cyc(5);
	endtask

	task automatic tForce;
		wr(OFF_STATUS, 32'h6);
		rd(OFF_STATUS);
		`CHECK(q, 32'h0)
		rd(OFF_IRQ_STAT);
		wr(OFF_CTRL, 32'h11);
		wr(OFF_STATUS, 32'h6);
		cyc(1);
		`CHECK({startOut, backupTrip}, 2'b11)
		repeat (60) if (startOut !== 1'b0) @(posedge clk);
		rd(OFF_CTRL);
		`CHECK(q, 32'h00000101)
		`CHECK(startOut, 1'b0)
		rd(OFF_IRQ_STAT);
		`CHECK(q[2], 1'b1)
		wr(OFF_PASSWORD, 32'h0);
		wr(OFF_CTRL, 32'h2);
		rd(OFF_CTRL);
		`CHECK(q, 32'h00000001)
	endtask

	task automatic print_verdict;
		$display("checks %0d errors %0d", numChecks, nErrors);
		if (nErrors == 0 && numChecks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			nErrors++;
			print_verdict();
		end
	end

	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		tSettings();
		tTrip();
		tEarly();
		tSelectBlock();
		tForce();
		print_verdict();
	end
endmodule
